// ==== logic/dlgc_top.sv ====
`timescale 1ns/10ps
`include "dlgc_defines.svh"
// Operation
// - damping select in bits 2:0, resets to 011 meaning factor five
// - effective damping depends on code and selected bandwidth class
// - gain peak reported follows the effective damping factor
// - main register: gain bits 6:4, damping bits 2:0, reset 0x13
// - aux register: enable bit 7, analog 6:4, digital 2:0, reset 0xc2
// - main low-rate analog gain drives detector only when selection enabled
// - aux analog gain ignored when gain selection disabled
module dlgc_top
  import dlgc_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [2:0]  main_low_rate_analog_gain,
  output logic      [2:0]  aux_analog_feedback_gain,
  output logic      [2:0]  aux_digital_feedback_gain,
  output logic             aux_gain_select_enable,
  output logic      [7:0]  damp_factor,
  output logic      [7:0]  gain_peak
);
  dlgc_state_t st;
  dlgc_state_t next_st;
  logic        setup;
  logic        wr_ok;
  logic        known;

  // setup phase answers in the access phase, one wait-free cycle
  assign setup = psel && !penable && !st.pready;

  always_comb
  begin
    next_st         = st;
    next_st.pready  = 1'b0;
    next_st.pslverr = 1'b0;
    known = (paddr == `DLGC_ADDR_MAIN_DAMP) ||
            (paddr == `DLGC_ADDR_AUX_GAIN) ||
            (paddr == `DLGC_ADDR_STATUS) ||
            (paddr == `DLGC_ADDR_BW_SEL);
    // write lands at the edge where the master sees pready high
    wr_ok = psel && penable && st.pready && pwrite && pstrb[0];
    if (setup)
    begin
      next_st.pready  = 1'b1;
      next_st.pslverr = !known;
      next_st.prdata  = 32'h0;
      if (!pwrite)
      begin
        case (paddr)
          `DLGC_ADDR_MAIN_DAMP: next_st.prdata = {24'h0, st.main_damp};
          `DLGC_ADDR_AUX_GAIN:  next_st.prdata = {24'h0, st.aux_gain};
          `DLGC_ADDR_STATUS:    next_st.prdata = {16'h0, gain_peak,
                                                  damp_factor};
          `DLGC_ADDR_BW_SEL:    next_st.prdata = {30'h0, st.bw_sel};
          default:              next_st.prdata = 32'h0;
        endcase
      end
    end
    // unused bits stay zero: 7 and 3 in main, 3 in aux
    if (wr_ok && paddr == `DLGC_ADDR_MAIN_DAMP)
      next_st.main_damp = pwdata[7:0] & `DLGC_MASK_MAIN_DAMP;
    if (wr_ok && paddr == `DLGC_ADDR_AUX_GAIN)
      next_st.aux_gain = pwdata[7:0] & `DLGC_MASK_AUX_GAIN;
    if (wr_ok && paddr == `DLGC_ADDR_BW_SEL)
      next_st.bw_sel = pwdata[1:0];
    // gain selection gates the analog gains, digital always used
    next_st.aux_en_out = st.aux_gain[`DLGC_AUX_EN_BIT];
    next_st.main_gain_out = st.aux_gain[`DLGC_AUX_EN_BIT] ?
                            st.main_damp[6:4] : 3'h0;
    next_st.aux_analog_out = st.aux_gain[`DLGC_AUX_EN_BIT] ?
                             st.aux_gain[6:4] : 3'h0;
    next_st.aux_digital_out = st.aux_gain[2:0];
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st           <= '0;
      st.main_damp <= `DLGC_RST_MAIN_DAMP;
      st.aux_gain  <= `DLGC_RST_AUX_GAIN;
    end
    else
      st <= next_st;
  end

  // translation from code to factor
  dlgc_damp_map i_dlgc_damp_map
  (
    .mclk        (mclk),
    .rst         (rst),
    .code        (st.main_damp[2:0]),
    .bw          (st.bw_sel),
    .damp_factor (damp_factor),
    .gain_peak   (gain_peak)
  );

  assign prdata                    = st.prdata;
  assign pready                    = st.pready;
  assign pslverr                   = st.pslverr;
  assign main_low_rate_analog_gain = st.main_gain_out;
  assign aux_analog_feedback_gain  = st.aux_analog_out;
  assign aux_digital_feedback_gain = st.aux_digital_out;
  assign aux_gain_select_enable    = st.aux_en_out;

  // bus protocol: each setup gets exactly one ready pulse
  a_ready_answer: assert property (
    @(posedge mclk) disable iff (rst)
    setup |=> pready)
    else $error("setup phase not answered");

  a_ready_once: assert property (
    @(posedge mclk) disable iff (rst)
    pready |=> !pready)
    else $error("ready held two cycles");

  a_idle_quiet: assert property (
    @(posedge mclk) disable iff (rst)
    !psel |=> !pready)
    else $error("ready without a request");

  // unmapped words answer with an error, mapped ones never do
  a_err_unmapped: assert property (
    @(posedge mclk) disable iff (rst)
    (setup && !known) |=> (pready && pslverr))
    else $error("unmapped address not flagged");

  a_err_mapped: assert property (
    @(posedge mclk) disable iff (rst)
    (setup && known) |=> !pslverr)
    else $error("error flagged on a mapped address");

  // writes land only at the edge where the master samples ready
  a_main_write: assert property (
    @(posedge mclk) disable iff (rst)
    (wr_ok && paddr == `DLGC_ADDR_MAIN_DAMP) |=>
      (st.main_damp == ($past(pwdata[7:0]) & `DLGC_MASK_MAIN_DAMP)))
    else $error("main register write lost");

  a_aux_write: assert property (
    @(posedge mclk) disable iff (rst)
    (wr_ok && paddr == `DLGC_ADDR_AUX_GAIN) |=>
      (st.aux_gain == ($past(pwdata[7:0]) & `DLGC_MASK_AUX_GAIN)))
    else $error("aux register write lost");

  // a cleared strobe bit 0 must leave the main and aux registers alone
  a_no_strobe: assert property (
    @(posedge mclk) disable iff (rst)
    (psel && penable && pready && pwrite && !pstrb[0]) |=>
      ($stable(st.main_damp) && $stable(st.aux_gain)))
    else $error("write without strobe changed a register");

  a_read_main: assert property (
    @(posedge mclk) disable iff (rst)
    (setup && !pwrite && paddr == `DLGC_ADDR_MAIN_DAMP) |=>
      (prdata == {24'h0, $past(st.main_damp)}))
    else $error("main register read wrong");

  // reset values, seen on the first edge after release
  a_reset_vals: assert property (
    @(posedge mclk)
    $fell(rst) |-> (st.main_damp == `DLGC_RST_MAIN_DAMP &&
                    st.aux_gain == `DLGC_RST_AUX_GAIN && st.bw_sel == 2'h0))
    else $error("register reset value wrong");

  a_reset_code: assert property (
    @(posedge mclk)
    $fell(rst) |-> (damp_factor == `DLGC_DF_5 && gain_peak == `DLGC_GP_0P1))
    else $error("damping after reset not five");

  // unused bits are masked on write, so they never hold a one
  a_reserved_bits: assert property (
    @(posedge mclk) disable iff (rst)
    (st.main_damp[7] == 1'b0) && (st.main_damp[3] == 1'b0))
    else $error("reserved bit set");

  a_aux_spare: assert property (
    @(posedge mclk) disable iff (rst)
    st.aux_gain[3] == 1'b0)
    else $error("aux spare bit set");

  // detector gains follow the registers one edge later
  a_aux_gate: assert property (
    @(posedge mclk) disable iff (rst)
    !st.aux_gain[`DLGC_AUX_EN_BIT] |=> (aux_analog_feedback_gain == 3'h0))
    else $error("aux analog gain not gated");

  a_aux_analog_on: assert property (
    @(posedge mclk) disable iff (rst)
    st.aux_gain[`DLGC_AUX_EN_BIT] |=>
      (aux_analog_feedback_gain == $past(st.aux_gain[6:4])))
    else $error("aux analog gain not applied");

  a_main_gate: assert property (
    @(posedge mclk) disable iff (rst)
    st.aux_gain[`DLGC_AUX_EN_BIT] |=>
      (main_low_rate_analog_gain == $past(st.main_damp[6:4])))
    else $error("main gain not applied");

  a_main_gate_off: assert property (
    @(posedge mclk) disable iff (rst)
    !st.aux_gain[`DLGC_AUX_EN_BIT] |=> (main_low_rate_analog_gain == 3'h0))
    else $error("main gain not gated");

  a_digital_follows: assert property (
    @(posedge mclk) disable iff (rst)
    1'b1 |=> (aux_digital_feedback_gain == $past(st.aux_gain[2:0])))
    else $error("digital gain does not follow register");

  a_enable_follows: assert property (
    @(posedge mclk) disable iff (rst)
    1'b1 |=> (aux_gain_select_enable == $past(st.aux_gain[7])))
    else $error("gain select enable does not follow register");

  // three steady cycles let the registered table catch up
  a_seventy_peak: assert property (
    @(posedge mclk) disable iff (rst)
    (st.bw_sel == 2'h3 && st.main_damp[2:0] == 3'h1) [*3] |->
      (gain_peak == `DLGC_GP_0P4))
    else $error("peak wrong at 70 hz");

  // main scenarios
  c_write_main: cover property (@(posedge mclk)
    wr_ok && paddr == `DLGC_ADDR_MAIN_DAMP);
  c_read_status: cover property (@(posedge mclk)
    setup && !pwrite && paddr == `DLGC_ADDR_STATUS);
  c_bad_addr: cover property (@(posedge mclk) pslverr);
  c_df_twenty: cover property (@(posedge mclk) damp_factor == 8'hc8);
endmodule : dlgc_top

// ==== inc/dlgc_defines.svh ====
`ifndef DLGC_DEFINES_SVH
`define DLGC_DEFINES_SVH
// register byte addresses on the apb bus
`define DLGC_ADDR_MAIN_DAMP   12'h000
`define DLGC_ADDR_AUX_GAIN    12'h004
`define DLGC_ADDR_STATUS      12'h008
`define DLGC_ADDR_BW_SEL      12'h00c
// reset values
`define DLGC_RST_MAIN_DAMP    8'h13
`define DLGC_RST_AUX_GAIN     8'hc2
`define DLGC_RST_DAMP_CODE    3'h3
// writable bit masks
`define DLGC_MASK_MAIN_DAMP   8'h77
`define DLGC_MASK_AUX_GAIN    8'hf7
// field positions
`define DLGC_AUX_EN_BIT       7
// damping factor, tenths
`define DLGC_DF_1P2           8'h0c
`define DLGC_DF_2P5           8'h19
`define DLGC_DF_5             8'h32
`define DLGC_DF_10            8'h64
`define DLGC_DF_20            8'hc8
// gain peak, hundredths of a db
`define DLGC_GP_0P4           8'h28
`define DLGC_GP_0P2           8'h14
`define DLGC_GP_0P1           8'h0a
`define DLGC_GP_0P06          8'h06
`define DLGC_GP_0P03          8'h03
`endif

// ==== inc/dlgc_pkg.sv ====
package dlgc_pkg;
  // loop bandwidth classes that shape the damping table
  typedef enum logic [1:0]
  {
    DLGC_BW_LE4,
    DLGC_BW_8,
    DLGC_BW_35,
    DLGC_BW_70
  } dlgc_bw_t;
  typedef struct packed
  {
    logic [7:0] damp_factor;
    logic [7:0] gain_peak;
  } dlgc_map_state_t;
  typedef struct packed
  {
    logic [7:0] main_damp;
    logic [7:0] aux_gain;
    logic [1:0] bw_sel;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [2:0]  main_gain_out;
    logic [2:0]  aux_analog_out;
    logic [2:0]  aux_digital_out;
    logic        aux_en_out;
  } dlgc_state_t;
endpackage : dlgc_pkg

// ==== logic/dlgc_damp_map.sv ====
`timescale 1ns/10ps
`include "dlgc_defines.svh"
module dlgc_damp_map
  import dlgc_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic [2:0] code,
  input  wire logic [1:0] bw,
  output logic      [7:0] damp_factor,
  output logic      [7:0] gain_peak
);
  dlgc_map_state_t st;
  dlgc_map_state_t next_st;
  logic [7:0] df;

  // table by bandwidth class, reserved codes fall back to default
  always_comb
  begin
    df = `DLGC_DF_5;
    case (code)
      3'h1: df = (bw == 2'h0) ? `DLGC_DF_5 :
                 (bw == 2'h1) ? `DLGC_DF_2P5 : `DLGC_DF_1P2;
      3'h2: df = (bw[1]) ? `DLGC_DF_2P5 : `DLGC_DF_5;
      3'h3: df = `DLGC_DF_5;
      3'h4: df = (bw[1]) ? `DLGC_DF_10 : `DLGC_DF_5;
      3'h5: df = (bw == 2'h3) ? `DLGC_DF_20 :
                 (bw == 2'h2) ? `DLGC_DF_10 : `DLGC_DF_5;
      default: df = `DLGC_DF_5;
    endcase
    next_st.damp_factor = df;
    case (df)
      `DLGC_DF_1P2: next_st.gain_peak = `DLGC_GP_0P4;
      `DLGC_DF_2P5: next_st.gain_peak = `DLGC_GP_0P2;
      `DLGC_DF_10:  next_st.gain_peak = `DLGC_GP_0P06;
      `DLGC_DF_20:  next_st.gain_peak = `DLGC_GP_0P03;
      default:      next_st.gain_peak = `DLGC_GP_0P1;
    endcase
  end

  // registered so outputs come from flops
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st.damp_factor <= `DLGC_DF_5;
      st.gain_peak   <= `DLGC_GP_0P1;
    end
    else
      st <= next_st;
  end

  assign damp_factor = st.damp_factor;
  assign gain_peak   = st.gain_peak;

  // peak and factor load from one next value, so they always agree
  a_peak_follows: assert property (
    @(posedge mclk) disable iff (rst)
    (damp_factor == `DLGC_DF_20) |-> (gain_peak == `DLGC_GP_0P03))
    else $error("gain peak does not follow damping");

  a_low_bw_five: assert property (
    @(posedge mclk) disable iff (rst)
    (bw == 2'h0) |=> (damp_factor == `DLGC_DF_5))
    else $error("low bandwidth damping not five");
endmodule : dlgc_damp_map

// ==== test/dlgc_top_bench.sv ====
`timescale 1ns/10ps
module dlgc_top_bench;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hf;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  mgain;
  logic [2:0]  again;
  logic [2:0]  dgain;
  logic        en;
  logic [7:0]  df;
  logic [7:0]  gp;
  int          bad_count = 0;
  int          checks_done = 0;
  // damping x10 and gain peak x100, one slot per factor
  logic [7:0]  dft [5] = '{8'h0c, 8'h19, 8'h32, 8'h64, 8'hc8};
  logic [7:0]  gpt [5] = '{8'h28, 8'h14, 8'h0a, 8'h06, 8'h03};

  always #2 mclk = ~mclk;

  dlgc_top i_dlgc_top (.mclk(mclk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .main_low_rate_analog_gain(mgain), .aux_analog_feedback_gain(again),
    .aux_digital_feedback_gain(dgain), .aux_gain_select_enable(en),
    .damp_factor(df), .gain_peak(gp));

  task finish_test;
    $display("checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      $display("Error %0t: got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask : chk

  // one apb transfer; a leading edge keeps release and next setup apart
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // no cycle limit here: a hang is left to the watchdog
    do
    begin
      @(posedge mclk);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task rdchk(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask : rdchk

  task t_reset;
    rdchk(12'h000, 32'h13, 1'b0);
    rdchk(12'h004, 32'hc2, 1'b0);
    rdchk(12'h008, 32'h0a32, 1'b0);
    chk({29'h0, dgain}, 32'h2);
    chk({29'h0, again}, 32'h4);
    chk({29'h0, mgain}, 32'h1);
    chk({31'h0, en}, 32'h1);
  endtask : t_reset

  // every code at every bandwidth class, reserved codes included
  task t_table;
    int idx;
    for (int b = 0; b < 4; b++)
    begin
      wr(12'h00c, b);
      for (int c = 0; c < 8; c++)
      begin
        wr(12'h000, c);
        repeat (4) @(posedge mclk);
        idx = (c == 0 || c > 5 || b == 0) ? 2 : c - 1;
        if (b == 1)
          idx = (c == 1) ? 1 : 2;
        if (b == 2 && idx == 4)
          idx = 3;
        chk({24'h0, df}, {24'h0, dft[idx]});
        chk({24'h0, gp}, {24'h0, gpt[idx]});
      end
    end
  endtask : t_table

  // gain selection off hides both analog gains, digital stays
  task t_gate;
    wr(12'h000, 32'h53);
    wr(12'h004, 32'h75);
    repeat (3) @(posedge mclk);
    chk({29'h0, mgain}, 32'h0);
    chk({29'h0, again}, 32'h0);
    chk({29'h0, dgain}, 32'h5);
    chk({31'h0, en}, 32'h0);
    wr(12'h004, 32'hf5);
    repeat (3) @(posedge mclk);
    chk({29'h0, mgain}, 32'h5);
    chk({29'h0, again}, 32'h7);
    chk({31'h0, en}, 32'h1);
  endtask : t_gate

  task t_access;
    wr(12'h000, 32'hff);
    rdchk(12'h000, 32'h77, 1'b0);
    wr(12'h004, 32'hff);
    rdchk(12'h004, 32'hf7, 1'b0);
    pstrb <= 4'h0;
    wr(12'h000, 32'h11);
    pstrb <= 4'hf;
    rdchk(12'h000, 32'h77, 1'b0);
    wr(12'h010, 32'h11);
    rdchk(12'h010, 32'h0, 1'b1);
    rdchk(12'h000, 32'h77, 1'b0);
    rdchk(12'h00c, 32'h3, 1'b0);
  endtask : t_access

  initial
  begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    t_reset;
    t_table;
    t_gate;
    t_access;
    finish_test;
  end

  // roughly twenty-seven times the expected run
  initial
  begin
    repeat (8000) @(posedge mclk);
    bad_count++;
    finish_test;
  end
endmodule : dlgc_top_bench
